// file: tb.sv
// Self-checking bench for the touch measurement block.
// Assumes tsf_pkg, the design and the pad model are compiled first.
`timescale 1ns/10ps
module tb
	import tsf_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awa, ara;
	logic awv, wv, bry, arv, rry, awr, wr, bv, arr, rv, irq, wakeup, sprev = 1'b0;
	logic [31:0] wd, rd;
	logic [1:0] br, rr;
	logic [TSF_PADS-1:0] pls, s_seen = '0;
	logic [TSF_PADS-1:0][7:0] swings;
	tsf_afe_t afe;
	int bad_count = 0, checks_done = 0, starts = 0, slen = 0;

	tsf_touch_fsm tsf_touch_fsm_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.pad_pulse_line(pls), .afe(afe), .wakeup(wakeup), .irq(irq));
	tsf_pad_model tsf_pad_model_inst (.aclk(aclk), .afe(afe), .swings(swings),
		.pad_pulse_line(pls));

	// ==========================================
	// Clock and strobe monitor
	initial forever #20 aclk = ~aclk;
	always @(posedge aclk) begin
		sprev <= |afe.pad_start;
		s_seen <= s_seen | afe.pad_start;
		if (|afe.pad_start && !sprev) begin
			starts <= starts + 1;
			slen <= 1;
		end else if (|afe.pad_start)
			slen <= slen + 1;
	end

	// ==========================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic conclude();
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tmo(input bit hit);
		if (hit) begin
			bad_count++;
			conclude();
		end
	endtask
	// Address and data are offered together and each released once taken
	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		logic ar, wk, b;
		logic [1:0] r;
		int n;
		n = 0;
		b = 1'b0;
		// One edge between transfers so bready is never set twice at once
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		while (!b && n < 1000) begin
			@(negedge aclk);
			{ar, wk, b, r} = {awr, wr, bv, br};
			@(posedge aclk);
			if (ar) awv <= 1'b0;
			if (wk) wv <= 1'b0;
			n++;
		end
		bry <= 1'b0;
		tmo(n >= 1000);
		chk("bresp", {30'h0, r}, {30'h0, TSF_RESP_OKAY});
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		int n;
		n = 0;
		v = 1'b0;
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		while (!v && n < 1000) begin
			@(negedge aclk);
			{ar, v, d, r} = {arr, rv, rd, rr};
			@(posedge aclk);
			if (ar) arv <= 1'b0;
			n++;
		end
		rry <= 1'b0;
		tmo(n >= 1000);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rdr(a, d, r);
		chk(nm, d, e);
	endtask
	task automatic wirq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 1000) begin
			@(negedge aclk);
			n++;
		end
		@(posedge aclk);
		tmo(n >= 1000);
	endtask

	// ==========================================
	// Scenarios
	task automatic s_reset();
		logic [31:0] d;
		logic [1:0] r;
		chk("afe", {10'h0, afe}, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		rdc("timing", TSF_A_TIMING, {TSF_XPD_RST, TSF_BIAS_RST});
		rdc("meas", TSF_A_MEAS, {16'h0, TSF_MEAS_RST});
		rdc("sleep", TSF_A_SLEEP, {16'h0, TSF_SLEEP_RST});
		rdc("ctrl", TSF_A_CTRL, 32'h1);
		rdr(8'h3c, d, r);
		chk("unmapped resp", {30'h0, r}, {30'h0, TSF_RESP_SLVERR});
		chk("unmapped data", d, 32'h0);
	endtask
	// Pad 3 sits on the threshold, pad 9 is left out of the work mask
	task automatic s_single();
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < TSF_PADS; i++) begin
			swings[i] <= 8'(5 + 5 * i);
			wrt(TSF_A_THR0 + 8'(4 * i), 32'h14);
		end
		wrt(TSF_A_MASKS, 32'h0001_01ff);
		wrt(TSF_A_IRQ_MASK, 32'h3);
		wrt(TSF_A_CTRL, 32'hb);
		chk("level", {31'h0, afe.initial_level_select}, 32'h1);
		wirq();
		for (int i = 0; i < TSF_PADS; i++)
			rdc("count", TSF_A_CNT0 + 8'(4 * i), (i < 9) ? 32'(5 + 5 * i) : 32'h0);
		rdr(TSF_A_STATUS, d, r);
		chk("touched", {22'h0, d[9:0]}, 32'h7);
		chk("wakeup", {31'h0, wakeup}, 32'h1);
		chk("start seen", {22'h0, s_seen}, 32'h1ff);
		chk("meas length", slen, 32'h101);
		rdc("istat", TSF_A_IRQ_STAT, 32'h3);
		wrt(TSF_A_IRQ_STAT, 32'h1);
		rdc("istat w1c", TSF_A_IRQ_STAT, 32'h2);
		chk("irq wake", {31'h0, irq}, 32'h1);
		wrt(TSF_A_IRQ_MASK, 32'h1);
		chk("irq masked", {31'h0, irq}, 32'h0);
		wrt(TSF_A_IRQ_STAT, 32'h2);
		wrt(TSF_A_IRQ_MASK, 32'h3);
		chk("irq clear", {31'h0, irq}, 32'h0);
	endtask
	task automatic s_both();
		chk("starts", starts, 32'h1);
		wrt(TSF_A_GROUPB, 32'h8);
		wrt(TSF_A_CTRL, 32'h7);
		wirq();
		chk("wake both off", {31'h0, wakeup}, 32'h0);
		rdc("recount", TSF_A_CNT0 + 8'h4, 32'ha);
		wrt(TSF_A_IRQ_STAT, 32'h3);
		wrt(TSF_A_GROUPB, 32'hc);
		wrt(TSF_A_CTRL, 32'h7);
		wirq();
		chk("wake both on", {31'h0, wakeup}, 32'h1);
		wrt(TSF_A_IRQ_STAT, 32'h3);
	endtask
	// Timer mode never stops by itself, so it runs last
	task automatic s_timer();
		int s0, n;
		wrt(TSF_A_MEAS, 32'h40);
		wrt(TSF_A_SLEEP, 32'h14);
		s0 = starts;
		n = 0;
		wrt(TSF_A_CTRL, 32'h0);
		while (starts < s0 + 3 && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		chk("timer starts", {31'h0, starts >= s0 + 3}, 32'h1);
		tmo(n >= 3000);
		n = 0;
		while (|afe.pad_start && n < 1000) begin
			@(posedge aclk);
			n++;
		end
		tmo(n >= 1000);
		chk("timer meas length", slen, 32'h41);
		wrt(TSF_A_CTRL, 32'h1);
	endtask

	initial begin
		{awv, wv, bry, arv, rry} = 5'h0;
		{awa, ara, wd} = 48'h0;
		swings = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		s_reset();
		s_single();
		s_both();
		s_timer();
		conclude();
	end
endmodule // tb

// file: tsf_pad_model.sv
// Behavioural model of the ten analogue touch pad front ends.
// Assumes pulses two aclk cycles high with two low between them.
`timescale 1ns/10ps
module tsf_pad_model
	import tsf_pkg::*;
(
	input  wire logic                      aclk,
	input  wire tsf_afe_t                  afe,
	input  wire logic [TSF_PADS-1:0][7:0]  swings,
	output logic      [TSF_PADS-1:0]       pad_pulse_line
);
	// ==========================================
	// Swing pulses
	logic [TSF_PADS-1:0]      start_q = '0;
	logic [TSF_PADS-1:0][9:0] left_q  = '0;
	logic [TSF_PADS-1:0]      pulse_q = '0;
	assign pad_pulse_line = pulse_q;
	// A fixed swing count per run keeps the expected counts exact
	// Two-cycle levels let the three-stage pin filter see them agree
	always @(posedge aclk) begin
		for (int i = 0; i < TSF_PADS; i++) begin
			start_q[i] <= afe.pad_start[i];
			if (afe.pad_start[i] && !start_q[i] && afe.pad_power_up[i] && afe.bias_power_up)
				left_q[i] <= {swings[i], 2'b00};
			else if (left_q[i] != 10'h0)
				left_q[i] <= left_q[i] - 10'h1;
			pulse_q[i] <= left_q[i][1];
		end
	end
endmodule // tsf_pad_model

// file: tsf_pkg.sv
// Constants, register map and carrier types for the touch measurement block.
// Assumes a single 8 MHz fast clock domain and an AXI4-Lite register master.
// Summary of operation
// - Software trigger starts one sequence when selected
// - Timer launches sequences repeatedly when deselected
// - Runs in sleep; sleep count sets interval
// - Clocked by fast clock, counts in cycles
// - Drive bias, pad power and start strobes
// - Work mask gates pad power and start
// - Count pad pulses, results readable per pad
// - Ten independent counters measure all pads together
// - Same fixed interval for every measurement
// - Touched when count below pad threshold
// - Two ten-bit masks define wake groups
// - Default wake on any group A touch
// - Option wakes only when both groups touched
// - Touch wakes processor from deep sleep
// - Initial level select passed to front ends
package tsf_pkg;
	// ==========================================
	// Sizes and timing
	localparam int          TSF_PADS       = 10;
	localparam int          TSF_CW         = 16;
	localparam int          TSF_FCLK_MHZ   = 8;
	localparam logic [15:0] TSF_BIAS_RST   = 16'h0008;
	localparam logic [15:0] TSF_XPD_RST    = 16'h0008;
	localparam logic [15:0] TSF_MEAS_RST   = 16'h0100;
	localparam logic [15:0] TSF_SLEEP_RST  = 16'h1000;
	localparam logic [15:0] TSF_THR_RST    = 16'h0000;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] TSF_A_CTRL      = 8'h00;
	localparam logic [7:0] TSF_A_TIMING    = 8'h04;
	localparam logic [7:0] TSF_A_MEAS      = 8'h08;
	localparam logic [7:0] TSF_A_SLEEP     = 8'h0c;
	localparam logic [7:0] TSF_A_MASKS     = 8'h10;
	localparam logic [7:0] TSF_A_GROUPB    = 8'h14;
	localparam logic [7:0] TSF_A_STATUS    = 8'h18;
	localparam logic [7:0] TSF_A_IRQ_STAT  = 8'h1c;
	localparam logic [7:0] TSF_A_IRQ_MASK  = 8'h20;
	localparam logic [7:0] TSF_A_THR0      = 8'h40;
	localparam logic [7:0] TSF_A_CNT0      = 8'h80;
	localparam logic [7:0] TSF_A_LIMIT     = 8'ha8;
	// CTRL bits
	localparam int TSF_B_SRC   = 0;
	localparam int TSF_B_TRIG  = 1;
	localparam int TSF_B_BOTH  = 2;
	localparam int TSF_B_LEVEL = 3;
	// Interrupt status bits
	localparam int TSF_I_DONE  = 0;
	localparam int TSF_I_WAKE  = 1;
	localparam logic [1:0] TSF_RESP_OKAY   = 2'b00;
	localparam logic [1:0] TSF_RESP_SLVERR = 2'b10;

	typedef enum logic [4:0] {
		TSF_IDLE  = 5'b00001,
		TSF_BIAS  = 5'b00010,
		TSF_XPD   = 5'b00100,
		TSF_MEAS  = 5'b01000,
		TSF_SLEEP = 5'b10000
	} tsf_state_t;

	typedef struct packed {
		logic                bias_power_up;
		logic [TSF_PADS-1:0] pad_power_up;
		logic [TSF_PADS-1:0] pad_start;
		logic                initial_level_select;
	} tsf_afe_t;
endpackage

// file: tsf_touch_fsm.sv
// Touch measurement state machine with AXI4-Lite registers and interrupt.
// Assumes pad pulse lines are asynchronous to aclk and resynchronised here.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module tsf_touch_fsm
	import tsf_pkg::*;
(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic [TSF_PADS-1:0] pad_pulse_line,
	output tsf_afe_t                 afe,
	output logic                     wakeup,
	output logic                     irq
);
	// ==========================================
	// State record
	typedef struct packed {
		tsf_state_t                       st;
		logic [15:0]                      tmr;
		logic                             src_sel;
		logic                             both_mode;
		logic                             level_sel;
		logic [15:0]                      bias_cyc;
		logic [15:0]                      xpd_cyc;
		logic [15:0]                      meas_cyc;
		logic [15:0]                      sleep_cyc;
		logic [TSF_PADS-1:0]              work_mask;
		logic [TSF_PADS-1:0]              grp_a;
		logic [TSF_PADS-1:0]              grp_b;
		logic [TSF_PADS-1:0][TSF_CW-1:0]  thr;
		logic [TSF_PADS-1:0][TSF_CW-1:0]  cnt;
		logic [TSF_PADS-1:0][TSF_CW-1:0]  res;
		logic [TSF_PADS-1:0]              touched;
		logic [TSF_PADS-1:0][2:0]         sync;
		logic [TSF_PADS-1:0]              lvl;
		logic [1:0]                       istat;
		logic [1:0]                       imask;
		logic                             wake;
		logic                             aw_got;
		logic                             w_got;
		logic [7:0]                       awaddr;
		logic [31:0]                      wdata;
		logic                             bvalid;
		logic [1:0]                       bresp;
		logic                             rvalid;
		logic [31:0]                      rdata;
		logic [1:0]                       rresp;
	} tsf_regs_t;

	tsf_regs_t s_q, s_d;

	// Pad index of a threshold or count address, or TSF_PADS when outside
	function automatic int pad_idx(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] off;
		off = a - base;
		if (a >= base && off[1:0] == 2'b00 && off[7:2] < 6'(TSF_PADS))
			return int'(off[7:2]);
		return TSF_PADS;
	endfunction

	logic [TSF_PADS-1:0] pulse_rise;
	logic [TSF_PADS-1:0] below;
	logic                trig_sw;
	logic                grp_hit;

	// ==========================================
	// Pad pulse resynchronisers, one counter per pad
	for (genvar g = 0; g < TSF_PADS; g++) begin : g_pad
		// Edge counted once stages two and three agree high against the old level
		assign pulse_rise[g] = s_q.sync[g][1] & s_q.sync[g][2] & ~s_q.lvl[g];
		assign below[g]      = s_q.cnt[g] < s_q.thr[g];
	end

	always_comb begin
		int pi;
		logic wr_go;
		logic rd_go;
		pi    = 0;
		s_d   = s_q;
		trig_sw = 1'b0;
		grp_hit = 1'b0;
		wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
		rd_go = s_axi_arvalid && !s_q.rvalid;

		for (int i = 0; i < TSF_PADS; i++) begin
			s_d.sync[i] = {s_q.sync[i][1:0], pad_pulse_line[i]};
			// A level is accepted only when stages two and three agree
			if (s_q.sync[i][1] == s_q.sync[i][2])
				s_d.lvl[i] = s_q.sync[i][2];
		end

		// ==========================================
		// AXI4-Lite write path
		if (s_axi_awvalid && !s_q.aw_got) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got) begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata;
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		if (wr_go) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = TSF_RESP_OKAY;
			case (s_q.awaddr)
				TSF_A_CTRL: begin
					s_d.src_sel   = s_q.wdata[TSF_B_SRC];
					s_d.both_mode = s_q.wdata[TSF_B_BOTH];
					s_d.level_sel = s_q.wdata[TSF_B_LEVEL];
					trig_sw       = s_q.wdata[TSF_B_TRIG];
				end
				TSF_A_TIMING: begin
					s_d.bias_cyc = s_q.wdata[15:0];
					s_d.xpd_cyc  = s_q.wdata[31:16];
				end
				TSF_A_MEAS:   s_d.meas_cyc  = s_q.wdata[15:0];
				TSF_A_SLEEP:  s_d.sleep_cyc = s_q.wdata[15:0];
				TSF_A_MASKS: begin
					s_d.work_mask = s_q.wdata[TSF_PADS-1:0];
					s_d.grp_a     = s_q.wdata[16+TSF_PADS-1:16];
				end
				TSF_A_GROUPB:   s_d.grp_b = s_q.wdata[TSF_PADS-1:0];
				TSF_A_IRQ_MASK: s_d.imask = s_q.wdata[1:0];
				TSF_A_IRQ_STAT: s_d.istat = s_q.istat & ~s_q.wdata[1:0];
				default: begin
					pi = pad_idx(s_q.awaddr, TSF_A_THR0);
					if (pi < TSF_PADS)
						s_d.thr[pi] = s_q.wdata[TSF_CW-1:0];
					else
						s_d.bresp = TSF_RESP_SLVERR;
				end
			endcase
		end

		// ==========================================
		// AXI4-Lite read path
		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (rd_go) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = TSF_RESP_OKAY;
			s_d.rdata  = '0;
			case (s_axi_araddr)
				TSF_A_CTRL: begin
					s_d.rdata[TSF_B_SRC]   = s_q.src_sel;
					s_d.rdata[TSF_B_BOTH]  = s_q.both_mode;
					s_d.rdata[TSF_B_LEVEL] = s_q.level_sel;
				end
				TSF_A_TIMING:   s_d.rdata = {s_q.xpd_cyc, s_q.bias_cyc};
				TSF_A_MEAS:     s_d.rdata[15:0] = s_q.meas_cyc;
				TSF_A_SLEEP:    s_d.rdata[15:0] = s_q.sleep_cyc;
				TSF_A_MASKS: begin
					s_d.rdata[TSF_PADS-1:0]       = s_q.work_mask;
					s_d.rdata[16+TSF_PADS-1:16]   = s_q.grp_a;
				end
				TSF_A_GROUPB:   s_d.rdata[TSF_PADS-1:0] = s_q.grp_b;
				TSF_A_STATUS: begin
					s_d.rdata[TSF_PADS-1:0] = s_q.touched;
					s_d.rdata[31:27]        = s_q.st;
				end
				TSF_A_IRQ_STAT: s_d.rdata[1:0] = s_q.istat;
				TSF_A_IRQ_MASK: s_d.rdata[1:0] = s_q.imask;
				default: begin
					pi = pad_idx(s_axi_araddr, TSF_A_THR0);
					if (pi < TSF_PADS)
						s_d.rdata[TSF_CW-1:0] = s_q.thr[pi];
					else begin
						pi = pad_idx(s_axi_araddr, TSF_A_CNT0);
						if (pi < TSF_PADS)
							s_d.rdata[TSF_CW-1:0] = s_q.res[pi];
						else
							s_d.rresp = TSF_RESP_SLVERR;
					end
				end
			endcase
		end

		// ==========================================
		// Measurement sequence, all counts in fast-clock cycles
		case (s_q.st)
			TSF_IDLE: begin
				if ((s_q.src_sel && trig_sw) || !s_q.src_sel) begin
					s_d.st  = TSF_BIAS;
					s_d.tmr = s_q.bias_cyc;
				end
			end
			TSF_BIAS: begin
				if (s_q.tmr == '0) begin
					s_d.st  = TSF_XPD;
					s_d.tmr = s_q.xpd_cyc;
				end else
					s_d.tmr = s_q.tmr - 16'h0001;
			end
			TSF_XPD: begin
				if (s_q.tmr == '0) begin
					s_d.st  = TSF_MEAS;
					s_d.tmr = s_q.meas_cyc;
					s_d.cnt = '0;
				end else
					s_d.tmr = s_q.tmr - 16'h0001;
			end
			TSF_MEAS: begin
				for (int i = 0; i < TSF_PADS; i++) begin
					if (pulse_rise[i] && s_q.work_mask[i] && s_q.cnt[i] != '1)
						s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
				end
				if (s_q.tmr == '0) begin
					// Results change only here, so reads never see a partial count
					s_d.res     = s_q.cnt;
					s_d.touched = below & s_q.work_mask;
					if (s_q.both_mode)
						grp_hit = |(below & s_q.work_mask & s_q.grp_a) &&
							|(below & s_q.work_mask & s_q.grp_b);
					else
						grp_hit = |(below & s_q.work_mask & s_q.grp_a);
					s_d.wake = grp_hit;
					s_d.istat[TSF_I_DONE] = 1'b1;
					if (grp_hit)
						s_d.istat[TSF_I_WAKE] = 1'b1;
					s_d.st  = s_q.src_sel ? TSF_IDLE : TSF_SLEEP;
					s_d.tmr = s_q.sleep_cyc;
				end else
					s_d.tmr = s_q.tmr - 16'h0001;
			end
			TSF_SLEEP: begin
				// Keeps cycling regardless of processor sleep state
				if (s_q.src_sel)
					s_d.st = TSF_IDLE;
				else if (s_q.tmr == '0) begin
					s_d.st  = TSF_BIAS;
					s_d.tmr = s_q.bias_cyc;
				end else
					s_d.tmr = s_q.tmr - 16'h0001;
			end
			default: s_d.st = TSF_IDLE;
		endcase

		// Write clear and a new event in the same cycle: the event is kept
		if (wr_go && s_q.awaddr == TSF_A_IRQ_STAT) begin
			if (s_q.st == TSF_MEAS && s_q.tmr == '0) begin
				s_d.istat[TSF_I_DONE] = 1'b1;
				s_d.istat[TSF_I_WAKE] = s_d.istat[TSF_I_WAKE] | grp_hit;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q           <= '0;
			s_q.st        <= TSF_IDLE;
			s_q.src_sel   <= 1'b1;
			s_q.bias_cyc  <= TSF_BIAS_RST;
			s_q.xpd_cyc   <= TSF_XPD_RST;
			s_q.meas_cyc  <= TSF_MEAS_RST;
			s_q.sleep_cyc <= TSF_SLEEP_RST;
			s_q.thr       <= {TSF_PADS{TSF_CW'(TSF_THR_RST)}};
		end else
			s_q <= s_d;
	end

	// ==========================================
	// Outputs
	assign s_axi_awready = !s_q.aw_got;
	assign s_axi_wready  = !s_q.w_got;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign afe = '{
		bias_power_up:        (s_q.st != TSF_IDLE && s_q.st != TSF_SLEEP),
		pad_power_up:         ((s_q.st == TSF_XPD || s_q.st == TSF_MEAS) ?
			s_q.work_mask : '0),
		pad_start:            ((s_q.st == TSF_MEAS) ? s_q.work_mask : '0),
		initial_level_select: s_q.level_sel
	};
	assign wakeup = s_q.wake;
	assign irq    = |(s_q.istat & s_q.imask);

	// ==========================================
	// Checks
	property p_start_sw;
		@(posedge aclk) disable iff (!aresetn)
		(s_q.st == TSF_IDLE && s_q.src_sel && !trig_sw) |=> s_q.st == TSF_IDLE;
	endproperty
	a_start_sw: assert property (p_start_sw) else $error("idle left without trigger");

	property p_start_tmr;
		@(posedge aclk) disable iff (!aresetn)
		(s_q.st == TSF_IDLE && !s_q.src_sel) |=> s_q.st == TSF_BIAS;
	endproperty
	a_start_tmr: assert property (p_start_tmr) else $error("timer mode did not start");

	property p_sleep_wait;
		@(posedge aclk) disable iff (!aresetn)
		(s_q.st == TSF_SLEEP && s_q.tmr != '0 && !s_q.src_sel) |=> s_q.st == TSF_SLEEP;
	endproperty
	a_sleep_wait: assert property (p_sleep_wait) else $error("sleep ended early");

	property p_mask_gate;
		@(posedge aclk) disable iff (!aresetn)
		(afe.pad_start & ~s_q.work_mask) == '0;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("masked pad started");

	property p_bias_first;
		@(posedge aclk) disable iff (!aresetn)
		(afe.pad_power_up != '0) |-> afe.bias_power_up;
	endproperty
	a_bias_first: assert property (p_bias_first) else $error("pad up without bias");

	property p_clear;
		@(posedge aclk) disable iff (!aresetn)
		(s_q.st == TSF_XPD && s_q.tmr == '0) |=> s_q.cnt == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("counters not cleared");

	property p_interval;
		@(posedge aclk) disable iff (!aresetn)
		(s_q.st == TSF_XPD && s_q.tmr == '0) |=> s_q.tmr == s_q.meas_cyc;
	endproperty
	a_interval: assert property (p_interval) else $error("interval not loaded");

	property p_result;
		@(posedge aclk) disable iff (!aresetn)
		(s_q.st == TSF_MEAS && s_q.tmr == '0) |=>
			s_q.res == $past(s_q.cnt) &&
			s_q.touched == ($past(below) & $past(s_q.work_mask));
	endproperty
	a_result: assert property (p_result) else $error("result not latched");

	property p_wake_a;
		@(posedge aclk) disable iff (!aresetn)
		(s_q.st == TSF_MEAS && s_q.tmr == '0 && !s_q.both_mode &&
			|(below & s_q.work_mask & s_q.grp_a)) |=> wakeup;
	endproperty
	a_wake_a: assert property (p_wake_a) else $error("group a touch no wake");

	property p_wake_both;
		@(posedge aclk) disable iff (!aresetn)
		(s_q.st == TSF_MEAS && s_q.tmr == '0 && s_q.both_mode &&
			!(|(below & s_q.work_mask & s_q.grp_b))) |=> !wakeup;
	endproperty
	a_wake_both: assert property (p_wake_both) else $error("wake without group b");
endmodule // tsf_touch_fsm
